// ===== include/uvp_pkg.sv
// Constants, register map and types of the undervoltage protection element
package uvp_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1_000_000; // Timebase tick, 1 ms
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_PER_UNIT = 10; // Trip/drop-out unit, 10 ms
  localparam int BLOCK_HOLD_MS = 20; // Block release hold
  localparam int RELAY_PULSE_MS = 100; // Trip relay pulse width

  // ==========================================================================
  // Scaling and setting ranges (hundredths)
  // ==========================================================================
  localparam int PCT_SCALE = 100;
  localparam int LOWV_POS_PCT = 40;
  localparam int LOWV_REM_PCT = 5;
  localparam int LEVEL_MIN = 10;
  localparam int LEVEL_MAX = 200;
  localparam int LEVEL_RST = 95;
  localparam int RATIO_MIN = 101;
  localparam int RATIO_MAX = 300;
  localparam int RATIO_RST = 105;
  localparam int PUD_MAX = 1000;
  localparam int PUD_RST = 5;
  localparam int TRIPD_MAX = 30000;
  localparam int TRIPD_RST = 200;
  localparam int DOD_MAX = 6000;
  localparam int DOD_RST = 20;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PU_DELAY = 6'h04;
  localparam logic [5:0] OFS_DO_DELAY = 6'h08;
  localparam logic [5:0] OFS_DO_RATIO = 6'h0C;
  localparam logic [5:0] OFS_LEVEL = 6'h10; // Plus 4 per group
  localparam logic [5:0] OFS_TRIP_DELAY = 6'h20; // Plus 4 per group
  localparam logic [5:0] OFS_PU_COUNT = 6'h30;
  localparam logic [5:0] OFS_TRIP_COUNT = 6'h34;
  localparam logic [5:0] OFS_STATE = 6'h38;
  localparam logic [11:0] ADDR_GCTRL = 12'h800;
  localparam logic [11:0] ADDR_STATUS = 12'h804;
  localparam logic [11:0] ADDR_MASK = 12'h808;

  // Field positions
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_BLK_LSB = 1;
  localparam int CTRL_RELAY_BIT = 3;
  localparam int CTRL_OPM_LSB = 4;
  localparam int GCTRL_EN_BIT = 0;
  localparam int GCTRL_GRP_LSB = 4;

  typedef enum logic [1:0] {
    UVP_IDLE,
    UVP_ARMING,
    UVP_ACTIVE,
    UVP_RELEASING
  } uvp_state_t;

endpackage : uvp_pkg

// ===== src/uvp_element.sv
// Undervoltage protection element with APB registers, several instances
//
// Operation
// - Positive-sequence variant picks up when that voltage drops below level.
// - Remanent variant watches only phase one-two voltage against the level.
// - Pickup level per group, 0.10 to 2.00 nominal, default 0.95.
// - Condition must hold for pickup delay, 0 to 1000 ms, default 5 ms.
// - Trip after per-group trip delay, 0 to 300 s, default 2 s.
// - Pickup held for drop-out delay, up to 60 s, default 0.20 s.
// - Release only above level times drop-out ratio, 1.01 to 3.00.
// - Pickup blockable by a selected user variable or none.
// - Pickup blockable by fuse-failure supervision.
// - Positive-sequence variant blocks below 40 percent of nominal.
// - Remanent variant blocks below 5 percent of nominal.
// - Block stays a short while after all block causes clear.
// - Trip mapped to a relay is delivered as a pulse.
// - Runs only when globally enabled and active group operate mode on.
// - Several independent instances, each with own settings.
// - Counter increments on each pickup event.
// - Counter increments on each trip event.
module uvp_element
  import uvp_pkg::*;
#(
  parameter int NUM_INST = 2,
  parameter int NUM_GROUPS = 4,
  parameter int NUM_VARS = 3,
  parameter int VOLT_W = 16,
  parameter int CNT_W = 16,
  parameter logic [15:0] VNOM_COUNTS = 16'h2710,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [VOLT_W-1:0] positive_sequence_voltage,
  input wire logic [VOLT_W-1:0] phase_one_two_voltage,
  input wire logic fuse_failure,
  input wire logic [NUM_VARS-1:0] user_variable,
  output logic [NUM_INST-1:0] pickup,
  output logic [NUM_INST-1:0] trip,
  output logic [NUM_INST-1:0] trip_relay,
  output logic irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int GW = (NUM_GROUPS > 1) ? $clog2(NUM_GROUPS) : 1;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Voltage below a fraction (hundredths) of nominal
  function automatic logic below_pct(input logic [VOLT_W-1:0] v,
                                     input logic [8:0] pct);
    return 48'(v) * 48'(PCT_SCALE) < 48'(pct) * 48'(VNOM_COUNTS);
  endfunction : below_pct

  // Voltage above level times drop-out ratio
  function automatic logic above_release(input logic [VOLT_W-1:0] v,
                                         input logic [7:0] lvl,
                                         input logic [8:0] ratio);
    return 48'(v) * 48'(PCT_SCALE * PCT_SCALE)
      > 48'(lvl) * 48'(ratio) * 48'(VNOM_COUNTS);
  endfunction : above_release

  // Clamp a written value into its setting range
  function automatic logic [15:0] clamp(input logic [31:0] val,
                                        input int lo,
                                        input int hi);
    if (val < 32'(lo)) begin
      return 16'(lo);
    end else if (val > 32'(hi)) begin
      return 16'(hi);
    end
    return val[15:0];
  endfunction : clamp

  // 10 ms units to ms ticks
  function automatic logic [18:0] units_to_ms(input logic [14:0] u);
    return 19'(u) * 19'(MS_PER_UNIT);
  endfunction : units_to_ms

  // ==========================================================================
  // Settings and state
  // ==========================================================================
  logic g_enable;
  logic [GW-1:0] act_grp;
  logic [2*NUM_INST-1:0] status;
  logic [2*NUM_INST-1:0] mask;
  logic variant [NUM_INST];
  logic [1:0] blk_src [NUM_INST];
  logic relay_mapped [NUM_INST];
  logic [NUM_GROUPS-1:0] opmode [NUM_INST];
  logic [9:0] pu_delay [NUM_INST];
  logic [12:0] do_delay [NUM_INST];
  logic [8:0] do_ratio [NUM_INST];
  logic [7:0] level [NUM_INST][NUM_GROUPS];
  logic [14:0] trip_delay [NUM_INST][NUM_GROUPS];
  logic [CNT_W-1:0] pu_count [NUM_INST];
  logic [CNT_W-1:0] trip_count [NUM_INST];
  uvp_state_t state [NUM_INST];
  logic [10:0] pu_tmr [NUM_INST];
  logic [15:0] do_tmr [NUM_INST];
  logic [18:0] trip_tmr [NUM_INST];
  logic [7:0] blk_tmr [NUM_INST];
  logic [7:0] pulse_tmr [NUM_INST];
  logic [NUM_INST-1:0] tripped;
  logic [NUM_INST-1:0] pickup_q;
  logic [NUM_INST-1:0] tripped_q;
  logic [TW-1:0] tick_cnt;
  logic tick;

  // Per-instance combinational view
  logic [VOLT_W-1:0] v_sel [NUM_INST];
  logic [NUM_INST-1:0] run;
  logic [NUM_INST-1:0] cond;
  logic [NUM_INST-1:0] release_ok;
  logic [NUM_INST-1:0] blk_raw;
  logic [NUM_INST-1:0] blocked;
  logic [NUM_INST-1:0] pu_evt;
  logic [NUM_INST-1:0] tr_evt;

  // APB decode
  logic setup;
  logic wr_acc;
  logic is_glob;
  logic [3:0] inst_sel;
  logic [5:0] reg_ofs;
  logic inst_ok;
  logic [31:0] next_rdata;
  logic next_err;

  // ==========================================================================
  // Timebase
  // ==========================================================================
  // Free-running 1 ms tick shared by every timer
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  // ==========================================================================
  // Measurement and blocking
  // ==========================================================================
  // Voltage select, thresholds and block causes per instance
  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      v_sel[i] = variant[i] ? phase_one_two_voltage
                            : positive_sequence_voltage;
      run[i] = g_enable && opmode[i][act_grp];
      cond[i] = below_pct(v_sel[i], 9'(level[i][act_grp]));
      release_ok[i] = above_release(v_sel[i], level[i][act_grp],
                                    do_ratio[i]);
      blk_raw[i] = fuse_failure
        || (blk_src[i] != 2'h0
            && user_variable[blk_src[i] - 2'h1])
        || (variant[i] ? below_pct(v_sel[i], 9'(LOWV_REM_PCT))
                       : below_pct(v_sel[i], 9'(LOWV_POS_PCT)));
      blocked[i] = blk_raw[i] || (blk_tmr[i] != 8'h00);
      pickup[i] = (state[i] == UVP_ACTIVE) || (state[i] == UVP_RELEASING);
      pu_evt[i] = pickup[i] && !pickup_q[i];
      tr_evt[i] = tripped[i] && !tripped_q[i];
    end
  end

  // Block hold timer reloads while any cause is present
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset) begin
        blk_tmr[i] <= '0;
      end else if (blk_raw[i]) begin
        blk_tmr[i] <= 8'(BLOCK_HOLD_MS);
      end else if (tick && blk_tmr[i] != 8'h00) begin
        blk_tmr[i] <= blk_tmr[i] - 8'h01;
      end
    end
  end

  // ==========================================================================
  // Pickup state machine
  // ==========================================================================
  // Pickup delay, hysteresis and drop-out hold per instance
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset) begin
        state[i] <= UVP_IDLE;
        pu_tmr[i] <= '0;
        do_tmr[i] <= '0;
      end else if (!run[i] || blocked[i]) begin
        state[i] <= UVP_IDLE;
        pu_tmr[i] <= '0;
        do_tmr[i] <= '0;
      end else begin
        unique case (state[i])
          UVP_IDLE: begin
            pu_tmr[i] <= '0;
            if (cond[i]) begin
              state[i] <= UVP_ARMING;
            end
          end
          UVP_ARMING: begin
            if (!cond[i]) begin
              state[i] <= UVP_IDLE;
            end else if (pu_tmr[i] >= 11'(pu_delay[i])) begin
              state[i] <= UVP_ACTIVE;
            end else if (tick) begin
              pu_tmr[i] <= pu_tmr[i] + 11'h001;
            end
          end
          UVP_ACTIVE: begin
            do_tmr[i] <= '0;
            if (release_ok[i]) begin
              state[i] <= UVP_RELEASING;
            end
          end
          UVP_RELEASING: begin
            if (!release_ok[i]) begin
              state[i] <= UVP_ACTIVE;
            end else if (19'(do_tmr[i]) >= units_to_ms(15'(do_delay[i]))) begin
              state[i] <= UVP_IDLE;
            end else if (tick) begin
              do_tmr[i] <= do_tmr[i] + 16'h0001;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Trip timing and relay pulse
  // ==========================================================================
  // Trip timer runs while pickup stands
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset || !pickup[i]) begin
        trip_tmr[i] <= '0;
        tripped[i] <= 1'b0;
      end else if (trip_tmr[i] >= units_to_ms(trip_delay[i][act_grp])) begin
        tripped[i] <= 1'b1;
      end else if (tick) begin
        trip_tmr[i] <= trip_tmr[i] + 19'h0_0001;
      end
    end
  end

  // Relay pulse started by each trip event
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset) begin
        pulse_tmr[i] <= '0;
      end else if (tr_evt[i]) begin
        pulse_tmr[i] <= 8'(RELAY_PULSE_MS);
      end else if (tick && pulse_tmr[i] != 8'h00) begin
        pulse_tmr[i] <= pulse_tmr[i] - 8'h01;
      end
    end
  end

  // Edge detectors for events
  always_ff @(posedge clk) begin
    if (reset) begin
      pickup_q <= '0;
      tripped_q <= '0;
    end else begin
      pickup_q <= pickup;
      tripped_q <= tripped;
    end
  end

  // Trip outputs
  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      trip[i] = tripped[i];
      trip_relay[i] = relay_mapped[i] ? (pulse_tmr[i] != 8'h00)
                                      : tripped[i];
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Address decode
  always_comb begin
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite;
    is_glob = paddr[11];
    inst_sel = paddr[9:6];
    reg_ofs = paddr[5:0];
    inst_ok = !paddr[11] && !paddr[10] && (32'(inst_sel) < 32'(NUM_INST));
  end

  assign pready = 1'b1;

  // Read mux, latched in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b1;
    if (is_glob) begin
      next_err = 1'b0;
      if (paddr == ADDR_GCTRL) begin
        next_rdata[GCTRL_EN_BIT] = g_enable;
        next_rdata[GCTRL_GRP_LSB +: GW] = act_grp;
      end else if (paddr == ADDR_STATUS) begin
        next_rdata[2*NUM_INST-1:0] = status;
      end else if (paddr == ADDR_MASK) begin
        next_rdata[2*NUM_INST-1:0] = mask;
      end else begin
        next_err = 1'b1;
      end
    end else if (inst_ok) begin
      next_err = 1'b0;
      for (int i = 0; i < NUM_INST; i++) begin
        if (32'(inst_sel) == i) begin
          unique case (reg_ofs)
            OFS_CTRL: begin
              next_rdata[CTRL_VARIANT_BIT] = variant[i];
              next_rdata[CTRL_BLK_LSB +: 2] = blk_src[i];
              next_rdata[CTRL_RELAY_BIT] = relay_mapped[i];
              next_rdata[CTRL_OPM_LSB +: NUM_GROUPS] = opmode[i];
            end
            OFS_PU_DELAY: next_rdata[9:0] = pu_delay[i];
            OFS_DO_DELAY: next_rdata[12:0] = do_delay[i];
            OFS_DO_RATIO: next_rdata[8:0] = do_ratio[i];
            OFS_PU_COUNT: next_rdata[CNT_W-1:0] = pu_count[i];
            OFS_TRIP_COUNT: next_rdata[CNT_W-1:0] = trip_count[i];
            OFS_STATE: next_rdata[3:0] = {cond[i], blocked[i], tripped[i],
                                          pickup[i]};
            default: begin
              next_err = 1'b1;
              for (int g = 0; g < NUM_GROUPS; g++) begin
                if (reg_ofs == OFS_LEVEL + 6'(4 * g)) begin
                  next_rdata[7:0] = level[i][g];
                  next_err = 1'b0;
                end
                if (reg_ofs == OFS_TRIP_DELAY + 6'(4 * g)) begin
                  next_rdata[14:0] = trip_delay[i][g];
                  next_err = 1'b0;
                end
              end
            end
          endcase
        end
      end
    end
  end

  // Registered read data and error
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= next_rdata;
      pslverr <= next_err;
    end
  end

  // Global control and interrupt mask
  always_ff @(posedge clk) begin
    if (reset) begin
      g_enable <= 1'b0;
      act_grp <= '0;
      mask <= '0;
    end else if (wr_acc && paddr == ADDR_GCTRL) begin
      g_enable <= pwdata[GCTRL_EN_BIT];
      act_grp <= pwdata[GCTRL_GRP_LSB +: GW];
    end else if (wr_acc && paddr == ADDR_MASK) begin
      mask <= pwdata[2*NUM_INST-1:0];
    end
  end

  // Per-instance settings, clamped into their ranges
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset) begin
        variant[i] <= 1'b0;
        blk_src[i] <= 2'h0;
        relay_mapped[i] <= 1'b0;
        opmode[i] <= '0;
        pu_delay[i] <= 10'(PUD_RST);
        do_delay[i] <= 13'(DOD_RST);
        do_ratio[i] <= 9'(RATIO_RST);
        for (int g = 0; g < NUM_GROUPS; g++) begin
          level[i][g] <= 8'(LEVEL_RST);
          trip_delay[i][g] <= 15'(TRIPD_RST);
        end
      end else if (wr_acc && inst_ok && 32'(inst_sel) == i) begin
        if (reg_ofs == OFS_CTRL) begin
          variant[i] <= pwdata[CTRL_VARIANT_BIT];
          blk_src[i] <= pwdata[CTRL_BLK_LSB +: 2];
          relay_mapped[i] <= pwdata[CTRL_RELAY_BIT];
          opmode[i] <= pwdata[CTRL_OPM_LSB +: NUM_GROUPS];
        end
        if (reg_ofs == OFS_PU_DELAY) begin
          pu_delay[i] <= 10'(clamp(pwdata, 0, PUD_MAX));
        end
        if (reg_ofs == OFS_DO_DELAY) begin
          do_delay[i] <= 13'(clamp(pwdata, 0, DOD_MAX));
        end
        if (reg_ofs == OFS_DO_RATIO) begin
          do_ratio[i] <= 9'(clamp(pwdata, RATIO_MIN, RATIO_MAX));
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
          if (reg_ofs == OFS_LEVEL + 6'(4 * g)) begin
            level[i][g] <= 8'(clamp(pwdata, LEVEL_MIN, LEVEL_MAX));
          end
          if (reg_ofs == OFS_TRIP_DELAY + 6'(4 * g)) begin
            trip_delay[i][g] <= 15'(clamp(pwdata, 0, TRIPD_MAX));
          end
        end
      end
    end
  end

  // ==========================================================================
  // Counters and interrupts
  // ==========================================================================
  // Event counters; a write clears, an event in the same cycle wins
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_INST; i++) begin
      if (reset) begin
        pu_count[i] <= '0;
        trip_count[i] <= '0;
      end else begin
        if (pu_evt[i]) begin
          pu_count[i] <= pu_count[i] + CNT_W'(1);
        end else if (wr_acc && inst_ok && 32'(inst_sel) == i
                     && reg_ofs == OFS_PU_COUNT) begin
          pu_count[i] <= '0;
        end
        if (tr_evt[i]) begin
          trip_count[i] <= trip_count[i] + CNT_W'(1);
        end else if (wr_acc && inst_ok && 32'(inst_sel) == i
                     && reg_ofs == OFS_TRIP_COUNT) begin
          trip_count[i] <= '0;
        end
      end
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (pu_evt[i]) begin
          status[2*i] <= 1'b1;
        end else if (wr_acc && paddr == ADDR_STATUS && pwdata[2*i]) begin
          status[2*i] <= 1'b0;
        end
        if (tr_evt[i]) begin
          status[2*i+1] <= 1'b1;
        end else if (wr_acc && paddr == ADDR_STATUS && pwdata[2*i+1]) begin
          status[2*i+1] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(status & mask);

endmodule : uvp_element

// ===== tb/uvp_chk.sv
// Port timing checker for the undervoltage protection element
module uvp_chk #(
  parameter int NUM_INST = 2,
  parameter int VOLT_W = 16,
  parameter logic [15:0] VNOM_COUNTS = 16'h2710,
  parameter int TICK_CYCLES = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [VOLT_W-1:0] positive_sequence_voltage,
  input wire logic [VOLT_W-1:0] phase_one_two_voltage,
  input wire logic fuse_failure,
  input wire logic [NUM_INST-1:0] pickup,
  input wire logic [NUM_INST-1:0] trip,
  input wire logic [NUM_INST-1:0] trip_relay,
  input wire logic irq
);
  localparam int LOW_V = VNOM_COUNTS * 5 / 100;
  logic [15:0] since_fuse;

  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // Clocks since fuse supervision last blocked, saturating
  always_ff @(posedge clk) begin
    if (reset) begin
      since_fuse <= 16'hFFFF;
    end else if (fuse_failure) begin
      since_fuse <= 16'h0000;
    end else if (since_fuse != 16'hFFFF) begin
      since_fuse <= since_fuse + 16'h0001;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h400
    |-> pslverr && prdata == 32'h0000_0000) else $error("no refusal");
  trip_after_pu_a: assert property (
    ((trip & ~$past(trip)) & ~pickup) == '0) else $error("trip alone");
  relay_with_trip_a: assert property (
    ((trip_relay & ~$past(trip_relay)) & ~trip) == '0)
    else $error("relay alone");
  fuse_block_a: assert property (
    fuse_failure |-> ##3 pickup == '0) else $error("fuse ignored");
  deep_sag_a: assert property (
    positive_sequence_voltage < LOW_V && phase_one_two_voltage < LOW_V
    |-> ##3 pickup == '0) else $error("sag ignored");
  block_hold_a: assert property (
    (pickup & ~$past(pickup)) != '0 |-> since_fuse > 19 * TICK_CYCLES)
    else $error("block hold short");
  quiet_reset_a: assert property (
    $fell(reset) |-> (pickup == '0 && irq == 1'b0) [*8])
    else $error("active after reset");
endmodule : uvp_chk

// ===== tb/uvp_element_test.sv
// Self-checking bench of the undervoltage protection element
module uvp_element_test;
  import uvp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 40;
  // Error flag, address, expected read value after reset
  localparam logic [44:0] ROWS [10] = '{
    {13'h0000, 32'h0000_0000}, {13'h0004, 32'(PUD_RST)},
    {13'h0008, 32'(DOD_RST)}, {13'h000C, 32'(RATIO_RST)},
    {13'h0010, 32'(LEVEL_RST)}, {13'h0060, 32'(TRIPD_RST)},
    {13'h0030, 32'h0000_0000}, {13'h0800, 32'h0000_0000},
    {13'h0808, 32'h0000_0000}, {13'h1400, 32'h0000_0000}};
  logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, ff, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] v1, v12;
  logic [2:0] uv;
  logic [1:0] pickup, trip, trip_relay;
  int failures = 0;
  int tests_run = 0;
  int n;

  uvp_front u_front (.clk(clk), .relay(trip_relay[0]),
    .positive_sequence_voltage(v1), .phase_one_two_voltage(v12),
    .fuse_failure(ff), .user_variable(uv));
  uvp_element #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .positive_sequence_voltage(v1), .phase_one_two_voltage(v12),
    .fuse_failure(ff), .user_variable(uv), .pickup(pickup), .trip(trip),
    .trip_relay(trip_relay), .irq(irq));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer
  task apb(input logic w, input logic [11:0] a,
           input logic [31:0] d = 32'h0000_0000);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      failures++;
      give_verdict();
    end
  endtask : apb

  // Bounded wait on pickup or trip
  task wt(input bit s, input int i, input logic val, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((s ? trip[i] : pickup[i]) !== val && n < lim);
    if (n >= lim) begin
      failures++;
      give_verdict();
    end
  endtask : wt

  task idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle

  // Block, unblock and time re-pickup
  task blk(input int a, input logic f, input logic [2:0] u);
    u_front.set(9000);
    wt(0, 0, 1'b1, 12 * TK);
    u_front.set(a, 10000, f, u);
    idle(4);
    chk("blocked pickup", 32'h0, pickup[0]);
    u_front.set(9000);
    wt(0, 0, 1'b1, 40 * TK);
    chk("block hold", 32'h1, n >= 19 * TK);
    $display("done block case");
  endtask : blk

  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i][43:32]);
      chk("reset value", ROWS[i][31:0], rd);
      chk("slave error", 32'(ROWS[i][44]), 32'(er));
    end
    apb(1'b1, 12'h010, 32'h0000_00FA);
    apb(1'b0, 12'h010);
    chk("level clamp", 32'(LEVEL_MAX), rd);
    apb(1'b1, 12'h010, 32'h0000_005F);
    apb(1'b1, 12'h000, 32'h0000_001A);
    apb(1'b1, 12'h020, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0001);
    apb(1'b1, 12'h040, 32'h0000_0011);
    apb(1'b1, 12'h060, 32'h0000_0001);
    apb(1'b1, 12'h808, 32'h0000_000F);
    apb(1'b1, 12'h800, 32'h0000_0001);
    $display("done registers");
    u_front.set(9000);
    repeat (3 * TK) @(posedge clk);
    u_front.set(10000);
    idle(10 * TK);
    chk("short dip", 32'h0, pickup[0]);
    u_front.set(9000);
    wt(0, 0, 1'b1, 8 * TK);
    chk("pickup time", 32'h1, n >= 4 * TK && n <= 6 * TK + 4);
    chk("other instance", 32'h0, pickup[1]);
    wt(1, 0, 1'b1, 12 * TK);
    chk("trip delay", 32'h1, n >= 9 * TK);
    idle(2);
    chk("relay", 32'h1, trip_relay[0]);
    chk("irq", 32'h1, irq);
    apb(1'b0, 12'h030);
    chk("pickup count", 32'h1, rd);
    apb(1'b0, 12'h034);
    chk("trip count", 32'h1, rd);
    idle(100 * TK);
    chk("relay pulse", 32'h0, trip_relay[0]);
    chk("trip level", 32'h1, trip[0]);
    chk("relay closings", 32'h1, u_front.relay_ops);
    apb(1'b1, 12'h804, 32'h0000_000F);
    idle(2);
    chk("irq cleared", 32'h0, irq);
    $display("done trip");
    u_front.set(9800);
    idle(20 * TK);
    chk("hysteresis", 32'h1, pickup[0]);
    u_front.set(10000);
    wt(0, 0, 1'b0, 20 * TK);
    chk("drop-out delay", 32'h1, n >= 9 * TK);
    u_front.set(10000, 9000);
    wt(0, 1, 1'b1, 8 * TK);
    chk("remanent only", 32'h0, pickup[0]);
    u_front.set(10000);
    wt(0, 1, 1'b0, 220 * TK);
    $display("done remanent");
    blk(9000, 1'b1, 3'b000);
    blk(9000, 1'b0, 3'b001);
    blk(3000, 1'b0, 3'b000);
    u_front.set(400, 400);
    idle(4);
    chk("deep sag", 32'h0, pickup);
    u_front.set(9000);
    wt(0, 0, 1'b1, 40 * TK);
    apb(1'b1, 12'h800, 32'h0000_0000);
    idle(4);
    chk("disabled", 32'h0, pickup[0]);
    $display("done disable");
    give_verdict();
  end
endmodule : uvp_element_test

bind uvp_element uvp_chk #(.NUM_INST(NUM_INST), .VOLT_W(VOLT_W),
  .VNOM_COUNTS(VNOM_COUNTS), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .positive_sequence_voltage(positive_sequence_voltage),
  .phase_one_two_voltage(phase_one_two_voltage),
  .fuse_failure(fuse_failure), .pickup(pickup), .trip(trip),
  .trip_relay(trip_relay), .irq(irq));

// ===== tb/uvp_front.sv
// Measurement front end and trip relay model
module uvp_front #(
  parameter int VOLT_W = 16,
  parameter int NUM_VARS = 3
) (
  input wire logic clk,
  input wire logic relay,
  output logic [VOLT_W-1:0] positive_sequence_voltage,
  output logic [VOLT_W-1:0] phase_one_two_voltage,
  output logic fuse_failure,
  output logic [NUM_VARS-1:0] user_variable
);
  timeunit 1ns;
  timeprecision 100ps;
  int relay_ops = 0;
  logic relay_q = 1'b0;

  // Healthy nominal voltages from time zero
  initial begin
    positive_sequence_voltage = VOLT_W'(10000);
    phase_one_two_voltage = VOLT_W'(10000);
    fuse_failure = 1'b0;
    user_variable = '0;
  end

  // Count relay closings seen by the breaker
  always @(posedge clk) begin
    relay_q <= relay;
    if (relay && !relay_q) begin
      relay_ops++;
    end
  end

  // New measurement set, applied at a rising edge
  task set(input int a, input int b = 10000, input logic f = 1'b0,
           input logic [NUM_VARS-1:0] u = '0);
    @(posedge clk);
    positive_sequence_voltage <= VOLT_W'(a);
    phase_one_two_voltage <= VOLT_W'(b);
    fuse_failure <= f;
    user_variable <= u;
  endtask : set
endmodule : uvp_front
